// file: dv/scsc_fb_model.sv
// partner model: secondary feedback that drives the enable pin
// assumes the bench says when the regulated output sits above target
`timescale 1ns/1ns

module scsc_fb_model #(
  parameter int LAG = 2  // opto response is LAG+1 clock cycles (LAG 0..7)
) (
  input  logic aclk,         // system clock
  input  logic above_target, // output above regulation point
  output logic enable_in     // enable pin level
);
  logic [7:0] pipe_r = 8'hFF;

  // opto pulls the pin low while the output is high, else the pull-up wins;
  // the lag stands in for the opto and reference response time
  always_ff @(posedge aclk) begin
    pipe_r <= {pipe_r[6:0], ~above_target};
  end
  assign enable_in = pipe_r[LAG];
endmodule // scsc_fb_model

// file: dv/skip_cycle_switch_control_tb.sv
// self-checking bench for the skip-cycle switch controller top
// assumes the 44 khz part, ce high except in the freeze check, feedback from scsc_fb_model
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); \
  end \
end

module skip_cycle_switch_control_tb;
  import scsc_pkg::*;
  typedef struct packed {
    scsc_addr_t a; logic w; scsc_word_t d; scsc_word_t e; logic [1:0] r;
  } scsc_row_t;
  logic       aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, above = 1'b0;
  scsc_addr_t awaddr = 4'h0, araddr = 4'h0;
  scsc_word_t wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'hF;
  logic       awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic       arvalid = 1'b0, rready = 1'b0, ilim_in = 1'b0;
  logic       supply_low_in = 1'b0, supply_ok_in = 1'b0;
  logic       temp_hot_in = 1'b0, temp_cool_in = 1'b0;
  logic       awready, wready, bvalid, arready, rvalid;
  logic       switch_drive, irq, enable_in;
  logic [1:0] bresp, rresp, resp;
  int         mismatches = 0, total_checks = 0, cyc = 0, t0, n;
  // unmapped row last so a refused write cannot leave state behind
  scsc_row_t  rows [7] = '{
    '{4'h0, 1'b0, 32'h0, 32'h1, 2'h0}, '{4'hC, 1'b0, 32'h0, 32'h0, 2'h0},
    '{4'h0, 1'b1, 32'h0, 32'h0, 2'h0}, '{4'h0, 1'b1, 32'h1, 32'h1, 2'h0},
    '{4'hC, 1'b1, 32'h1F, 32'h1F, 2'h0}, '{4'hC, 1'b1, 32'h0, 32'h0, 2'h0},
    '{4'h2, 1'b1, 32'hFF, 32'h0, 2'h2}};

  scsc_top u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .enable_in(enable_in), .ilim_in(ilim_in),
    .supply_low_in(supply_low_in), .supply_ok_in(supply_ok_in),
    .temp_hot_in(temp_hot_in), .temp_cool_in(temp_cool_in),
    .switch_drive(switch_drive), .irq(irq));
  scsc_fb_model #(.LAG(2)) u_fb (.aclk(aclk), .above_target(above),
    .enable_in(enable_in));

  always #4 aclk = ~aclk;

  // run is about 40k cycles; the ceiling leaves margin for slow answers
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      results();
    end
  end

  // ------------------------------------------------------------------
  // bus and wait helpers
  // ------------------------------------------------------------------
  task automatic results();
    if (mismatches == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // each bus task lets an edge pass first so no signal is set twice
  task automatic wr(input scsc_addr_t a, input scsc_word_t d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdr(input scsc_addr_t a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic sw(input logic v);
    do @(posedge aclk); while (switch_drive !== v);
  endtask

  task automatic rise();
    sw(1'b0);
    sw(1'b1);
  endtask

  task automatic hold(input int k);
    n = 0;
    repeat (k) begin
      @(posedge aclk);
      if (switch_drive !== 1'b0) n++;
    end
  endtask

  task automatic cut();
    n = 0;
    while (switch_drive !== 1'b0 && n < 10) begin
      @(posedge aclk);
      n++;
    end
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    `CHK("drive_rst", 1'b0, switch_drive)
    `CHK("irq_rst", 1'b0, irq)
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
        `CHK("bresp", rows[i].r, resp)
      end
      rdr(rows[i].a);
      `CHK("rdata", rows[i].e, rd)
      `CHK("rresp", rows[i].r, resp)
    end
    hold(3000);
    `CHK("uv_at_reset", 0, n)
    supply_ok_in <= 1'b1;
    // enable wobble inside the on-time must not end the pulse
    sw(1'b1);
    t0 = cyc;
    repeat (100) @(posedge aclk);
    above <= 1'b1;
    repeat (200) @(posedge aclk);
    above <= 1'b0;
    sw(1'b0);
    `CHK("on_time", 1'b1, (cyc - t0) inside {[1901:1903]})
    sw(1'b1);
    `CHK("period", 2840, cyc - t0)
    t0 = cyc;
    above <= 1'b1;
    repeat (4000) @(posedge aclk);
    above <= 1'b0;
    rise();
    `CHK("skip", 5680, cyc - t0)
    t0 = cyc;
    rise();
    `CHK("fast", 1420, cyc - t0)
    t0 = cyc;
    rise();
    `CHK("normal", 2840, cyc - t0)
    rdr(4'h8);
    `CHK("isr_skip", 2'h3, {rd[2], rd[0]})
    `CHK("irq_masked", 1'b0, irq)
    wr(4'hC, 32'h1);
    repeat (2) @(posedge aclk);
    `CHK("irq_on", 1'b1, irq)
    wr(4'h8, 32'h1);
    repeat (2) @(posedge aclk);
    `CHK("irq_off", 1'b0, irq)
    // spike inside blanking, then a real trip
    rise();
    t0 = cyc;
    ilim_in <= 1'b1;
    repeat (10) @(posedge aclk);
    ilim_in <= 1'b0;
    repeat (40) @(posedge aclk);
    `CHK("blank", 1'b1, switch_drive)
    ilim_in <= 1'b1;
    cut();
    `CHK("ilim_cut", 1'b1, n <= 5)
    ilim_in <= 1'b0;
    sw(1'b1);
    `CHK("ilim_rest", 2840, cyc - t0)
    supply_low_in <= 1'b1;
    supply_ok_in <= 1'b0;
    cut();
    `CHK("uv_cut", 1'b1, n <= 5)
    supply_low_in <= 1'b0;
    rdr(4'h4);
    `CHK("uv_state", 1'b1, rd[3])
    hold(3000);
    `CHK("uv_hold", 0, n)
    supply_ok_in <= 1'b1;
    t0 = cyc;
    sw(1'b1);
    // two edges of sync and one of the latch before the lockout lifts, then up to one period
    `CHK("uv_back", 1'b1, (cyc - t0) inside {[5:2844]})
    repeat (100) @(posedge aclk);
    temp_hot_in <= 1'b1;
    cut();
    `CHK("ot_cut", 1'b1, n <= 5)
    temp_hot_in <= 1'b0;
    hold(3000);
    `CHK("ot_hold", 0, n)
    rdr(4'h8);
    `CHK("isr_locks", 2'h3, rd[4:3])
    temp_cool_in <= 1'b1;
    t0 = cyc;
    sw(1'b1);
    `CHK("ot_back", 1'b1, (cyc - t0) inside {[5:2844]})
    // ce low must freeze the pulse well past its window end
    ce <= 1'b0;
    repeat (2000) @(posedge aclk);
    `CHK("ce_freeze", 1'b1, switch_drive)
    // mid-run reset: switch off, irq clear and lockout set again
    ce <= 1'b1;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    `CHK("drive_rst2", 1'b0, switch_drive)
    `CHK("irq_rst2", 1'b0, irq)
    rdr(4'h4);
    `CHK("state_rst2", 2'h2, {rd[3], rd[0]})
    results();
  end
endmodule // skip_cycle_switch_control_tb

// file: hdl/scsc_defs.svh
// constants for the skip-cycle switch controller
// assumes a 125 mhz clock; included by bare name from every design file
`ifndef SCSC_DEFS_SVH
`define SCSC_DEFS_SVH

// clock and oscillator
`define SCSC_CLK_HZ        125000000
`define SCSC_CLK_MHZ       125
`define SCSC_F_NORM_HZ     44000
`define SCSC_F_FAST_HZ     130000
`define SCSC_PER_NORM      (`SCSC_CLK_HZ / `SCSC_F_NORM_HZ)
`define SCSC_PER_FAST      (`SCSC_CLK_HZ / `SCSC_F_FAST_HZ)
`define SCSC_DUTY_PCT      67

// turn-on blanking, least time so rounded up
`define SCSC_TURN_ON_BLANKING_TIME_NS 200
`define SCSC_BLANK_CYC \
  ((`SCSC_TURN_ON_BLANKING_TIME_NS * `SCSC_CLK_MHZ + 999) / 1000)

// register byte addresses
`define SCSC_ADDR_CTRL     4'h0
`define SCSC_ADDR_STATE    4'h4
`define SCSC_ADDR_ISR      4'h8
`define SCSC_ADDR_IMR      4'hC

// reset values and field positions
`define SCSC_CTRL_RST      1'b1
`define SCSC_IMR_RST       5'h00
`define SCSC_EV_SKIP       0
`define SCSC_EV_LIM        1
`define SCSC_EV_DUTY       2
`define SCSC_EV_UV         3
`define SCSC_EV_OT         4
`define SCSC_EV_W          5

`endif

// file: hdl/scsc_osc.sv
// free-running oscillator: cycle-start strobe and max on-time window
// assumes skip_mode is registered logic on the same clock
`timescale 1ns/1ns
`include "scsc_defs.svh"

module scsc_osc #(
  parameter bit FAST = 1'b0  // higher-rate variant
) (
  input  logic aclk,               // system clock
  input  logic aresetn,            // sync reset, active low
  input  logic ce,                 // clock enable
  input  logic skip_mode,          // cycles are being skipped
  output logic cyc_start,          // one-cycle strobe at cycle start
  output logic max_on_time_bound   // high while on-time is allowed
);
  import scsc_pkg::*;

  localparam scsc_cnt_t PER_N =
    scsc_cnt_t'(FAST ? `SCSC_PER_FAST : `SCSC_PER_NORM);

  scsc_cnt_t cnt_r, cnt_nxt;
  scsc_cnt_t per_r, per_nxt;
  logic      cyc_r, cyc_nxt;
  logic      win_r, win_nxt;
  logic      wrap;

  // -------------------------------------------------------------------
  // counter
  // -------------------------------------------------------------------
  always_comb begin
    wrap    = (cnt_r >= per_r - 12'h001);
    cnt_nxt = wrap ? 12'h000 : cnt_r + 12'h001;
    // period is latched per cycle so a cycle never changes length
    per_nxt = per_r;
    if (wrap) begin
      per_nxt = (skip_mode && !FAST) ? (PER_N >> 1) : PER_N;
    end
    cyc_nxt = wrap;
    win_nxt = wrap ? 1'b1 : (cnt_nxt < scsc_duty_len(per_r));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 12'h000;
      per_r <= PER_N;
      cyc_r <= 1'b0;
      win_r <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      per_r <= per_nxt;
      cyc_r <= cyc_nxt;
      win_r <= win_nxt;
    end
  end

  assign cyc_start         = cyc_r;
  assign max_on_time_bound = win_r;
endmodule // scsc_osc

// file: hdl/scsc_pkg.sv
// types shared by the skip-cycle switch controller files
// assumes scsc_defs.svh for all figures
`include "scsc_defs.svh"

package scsc_pkg;
  typedef logic [11:0] scsc_cnt_t;
  typedef logic [31:0] scsc_word_t;
  typedef logic [3:0]  scsc_addr_t;
  typedef enum logic [1:0] {SW_OFF, SW_BLANK, SW_ON} scsc_sw_t;
  typedef enum logic [2:0] {R_CTRL, R_STATE, R_ISR, R_IMR, R_NONE}
    scsc_reg_t;

  // length of the max on-time window for a given period
  function automatic scsc_cnt_t scsc_duty_len(input scsc_cnt_t per);
    logic [31:0] p;
    p = 32'(per) * 32'(`SCSC_DUTY_PCT);
    return scsc_cnt_t'(p / 32'd100);
  endfunction
endpackage

// file: hdl/scsc_prot.sv
// hysteretic under-voltage and over-temperature lockouts
// assumes synchronised comparator levels on the same clock
`timescale 1ns/1ns
`include "scsc_defs.svh"

module scsc_prot (
  input  logic aclk,         // system clock
  input  logic aresetn,      // sync reset, active low
  input  logic ce,           // clock enable
  input  logic supply_low,   // supply node under lower level
  input  logic supply_ok,    // supply node back at upper level
  input  logic temp_hot,     // junction above shutdown level
  input  logic temp_cooled,  // junction fell by the hysteresis
  output logic uv_lock,      // under-voltage lockout active
  output logic ot_lock,      // thermal shutdown active
  output logic uv_trip,      // pulse when lockout is entered
  output logic ot_trip       // pulse when shutdown is entered
);
  logic uv_r, uv_nxt, ot_r, ot_nxt;
  logic uvt_r, uvt_nxt, ott_r, ott_nxt;

  // -------------------------------------------------------------------
  // lockout latches
  // -------------------------------------------------------------------
  always_comb begin
    uv_nxt = uv_r;
    if (supply_low) begin
      uv_nxt = 1'b1;
    end else if (supply_ok) begin
      uv_nxt = 1'b0;
    end
    ot_nxt = ot_r;
    if (temp_hot) begin
      ot_nxt = 1'b1;
    end else if (temp_cooled) begin
      ot_nxt = 1'b0;
    end
    uvt_nxt = uv_nxt && !uv_r;
    ott_nxt = ot_nxt && !ot_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uv_r  <= 1'b1;
      ot_r  <= 1'b0;
      uvt_r <= 1'b0;
      ott_r <= 1'b0;
    end else if (ce) begin
      uv_r  <= uv_nxt;
      ot_r  <= ot_nxt;
      uvt_r <= uvt_nxt;
      ott_r <= ott_nxt;
    end
  end

  assign uv_lock = uv_r;
  assign ot_lock = ot_r;
  assign uv_trip = uvt_r;
  assign ot_trip = ott_r;
endmodule // scsc_prot

// file: hdl/scsc_top.sv
// skip-cycle switch controller top: pin sync, switch fsm, axi4-lite regs
// assumes one clock; enable and comparator inputs arrive asynchronously
//
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "scsc_defs.svh"

module scsc_top #(
  parameter bit FAST_VARIANT = 1'b0  // 130 khz part
) (
  input  logic               aclk,          // 125 mhz clock
  input  logic               aresetn,       // sync reset, active low
  input  logic               ce,            // clock enable
  input  scsc_pkg::scsc_addr_t awaddr,      // write address
  input  logic               awvalid,       // write address valid
  output logic               awready,       // write address ready
  input  scsc_pkg::scsc_word_t wdata,       // write data
  input  logic [3:0]         wstrb,         // write byte strobes
  input  logic               wvalid,        // write data valid
  output logic               wready,        // write data ready
  output logic [1:0]         bresp,         // write response
  output logic               bvalid,        // write response valid
  input  logic               bready,        // write response ready
  input  scsc_pkg::scsc_addr_t araddr,      // read address
  input  logic               arvalid,       // read address valid
  output logic               arready,       // read address ready
  output scsc_pkg::scsc_word_t rdata,       // read data
  output logic [1:0]         rresp,         // read response
  output logic               rvalid,        // read data valid
  input  logic               rready,        // read data ready
  input  logic               enable_in,     // feedback enable pin
  input  logic               ilim_in,       // current-limit comparator
  input  logic               supply_low_in, // internal_supply_node < low
  input  logic               supply_ok_in,  // internal_supply_node >= up
  input  logic               temp_hot_in,   // over-temperature level
  input  logic               temp_cool_in,  // cooled by the hysteresis
  output logic               switch_drive,  // power switch gate
  output logic               irq            // level interrupt
);
  import scsc_pkg::*;

  localparam logic [7:0] BLANK = 8'(`SCSC_BLANK_CYC);

  // -------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------
  logic [5:0] sync_a_r, sync_b_r;
  logic       en_s, ilim_s, sl_s, so_s, th_s, tc_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a_r <= 6'h00;
      sync_b_r <= 6'h00;
    end else if (ce) begin
      sync_a_r <= {temp_cool_in, temp_hot_in, supply_ok_in,
                   supply_low_in, ilim_in, enable_in};
      sync_b_r <= sync_a_r;
    end
  end

  assign {tc_s, th_s, so_s, sl_s, ilim_s, en_s} = sync_b_r;

  // -------------------------------------------------------------------
  // oscillator and protection
  // -------------------------------------------------------------------
  logic cyc_start, max_on_time_bound;
  logic uv_lock, ot_lock, uv_trip, ot_trip;
  logic skip_r, skip_nxt;

  scsc_osc #(.FAST(FAST_VARIANT)) u_osc (
    .aclk              (aclk),
    .aresetn           (aresetn),
    .ce                (ce),
    .skip_mode         (skip_r),
    .cyc_start         (cyc_start),
    .max_on_time_bound (max_on_time_bound)
  );

  scsc_prot u_prot (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .ce          (ce),
    .supply_low  (sl_s),
    .supply_ok   (so_s),
    .temp_hot    (th_s),
    .temp_cooled (tc_s),
    .uv_lock     (uv_lock),
    .ot_lock     (ot_lock),
    .uv_trip     (uv_trip),
    .ot_trip     (ot_trip)
  );

  // -------------------------------------------------------------------
  // switch fsm
  // -------------------------------------------------------------------
  scsc_sw_t   st_r, st_nxt;
  logic [7:0] blank_r, blank_nxt;
  logic       sw_r, sw_nxt;
  logic       run_r;
  logic       ev_lim, ev_duty, ev_skip;

  always_comb begin
    st_nxt    = st_r;
    blank_nxt = blank_r;
    skip_nxt  = skip_r;
    ev_lim    = 1'b0;
    ev_duty   = 1'b0;
    ev_skip   = cyc_start && !en_s;
    if (cyc_start) begin
      skip_nxt = !en_s;
    end
    case (st_r)
      SW_OFF: begin
        // sampled only on the strobe; later changes are ignored
        if (cyc_start && en_s && run_r && !uv_lock && !ot_lock) begin
          st_nxt    = SW_BLANK;
          blank_nxt = BLANK - 8'h01;
        end
      end
      SW_BLANK: begin
        if (blank_r == 8'h00) begin
          st_nxt = SW_ON;
        end else begin
          blank_nxt = blank_r - 8'h01;
        end
      end
      SW_ON: begin
        if (ilim_s) begin
          st_nxt = SW_OFF;
          ev_lim = 1'b1;
        end
      end
      default: st_nxt = SW_OFF;
    endcase
    if (st_r != SW_OFF && !max_on_time_bound && !ev_lim) begin
      st_nxt  = SW_OFF;
      ev_duty = 1'b1;
    end
    if (uv_lock || ot_lock) begin
      st_nxt = SW_OFF;
    end
    sw_nxt = (st_nxt != SW_OFF);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r    <= SW_OFF;
      blank_r <= 8'h00;
      skip_r  <= 1'b0;
      sw_r    <= 1'b0;
    end else if (ce) begin
      st_r    <= st_nxt;
      blank_r <= blank_nxt;
      skip_r  <= skip_nxt;
      sw_r    <= sw_nxt;
    end
  end

  // -------------------------------------------------------------------
  // axi4-lite slave and registers
  // -------------------------------------------------------------------
  function automatic scsc_reg_t reg_sel(input scsc_addr_t a);
    if (a == `SCSC_ADDR_CTRL) begin
      return R_CTRL;
    end else if (a == `SCSC_ADDR_STATE) begin
      return R_STATE;
    end else if (a == `SCSC_ADDR_ISR) begin
      return R_ISR;
    end else if (a == `SCSC_ADDR_IMR) begin
      return R_IMR;
    end else begin
      return R_NONE;
    end
  endfunction

  logic                aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  scsc_addr_t          wa_r, wa_nxt;
  scsc_word_t          wd_r, wd_nxt;
  logic [3:0]          ws_r, ws_nxt;
  logic                awr_r, awr_nxt, wr_r, wr_nxt, arr_r, arr_nxt;
  logic                bv_r, bv_nxt, rv_r, rv_nxt;
  logic [1:0]          br_r, br_nxt, rr_r, rr_nxt;
  scsc_word_t          rd_r, rd_nxt;
  logic                run_nxt;
  logic [`SCSC_EV_W-1:0] isr_r, isr_nxt, imr_r, imr_nxt, ev, clr;
  logic                irq_r, irq_nxt, wr_go;

  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    wa_nxt     = wa_r;
    wd_nxt     = wd_r;
    ws_nxt     = ws_r;
    br_nxt     = br_r;
    rr_nxt     = rr_r;
    rd_nxt     = rd_r;
    run_nxt    = run_r;
    imr_nxt    = imr_r;
    clr        = '0;
    if (awvalid && awr_r) begin
      aw_got_nxt = 1'b1;
      wa_nxt     = awaddr;
    end
    if (wvalid && wr_r) begin
      w_got_nxt = 1'b1;
      wd_nxt    = wdata;
      ws_nxt    = wstrb;
    end
    // both halves held, then one cycle to commit and answer
    wr_go = aw_got_r && w_got_r && !bv_r;
    if (wr_go) begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      br_nxt     = 2'b00;
      if (reg_sel(wa_r) == R_CTRL) begin
        if (ws_r[0]) run_nxt = wd_r[0];
      end else if (reg_sel(wa_r) == R_ISR) begin
        if (ws_r[0]) clr = wd_r[`SCSC_EV_W-1:0];
      end else if (reg_sel(wa_r) == R_IMR) begin
        if (ws_r[0]) imr_nxt = wd_r[`SCSC_EV_W-1:0];
      end else if (reg_sel(wa_r) == R_NONE) begin
        br_nxt = 2'b10;
      end
    end
    bv_nxt  = wr_go || (bv_r && !bready);
    awr_nxt = !aw_got_nxt && !bv_nxt;
    wr_nxt  = !w_got_nxt && !bv_nxt;
    if (arvalid && arr_r) begin
      rr_nxt = 2'b00;
      rd_nxt = 32'h0000_0000;
      if (reg_sel(araddr) == R_CTRL) begin
        rd_nxt[0] = run_r;
      end else if (reg_sel(araddr) == R_STATE) begin
        rd_nxt[4:0] = {ot_lock, uv_lock, skip_r, en_s, sw_r};
      end else if (reg_sel(araddr) == R_ISR) begin
        rd_nxt[`SCSC_EV_W-1:0] = isr_r;
      end else if (reg_sel(araddr) == R_IMR) begin
        rd_nxt[`SCSC_EV_W-1:0] = imr_r;
      end else begin
        rr_nxt = 2'b10;
      end
    end
    rv_nxt  = (arvalid && arr_r) || (rv_r && !rready);
    arr_nxt = !rv_nxt;
    ev = '0;
    ev[`SCSC_EV_SKIP] = ev_skip;
    ev[`SCSC_EV_LIM]  = ev_lim;
    ev[`SCSC_EV_DUTY] = ev_duty;
    ev[`SCSC_EV_UV]   = uv_trip;
    ev[`SCSC_EV_OT]   = ot_trip;
    // a new event wins over a clear in the same cycle
    isr_nxt = (isr_r & ~clr) | ev;
    irq_nxt = |(isr_nxt & imr_nxt);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      wa_r     <= 4'h0;
      wd_r     <= 32'h0000_0000;
      ws_r     <= 4'h0;
      awr_r    <= 1'b0;
      wr_r     <= 1'b0;
      arr_r    <= 1'b0;
      bv_r     <= 1'b0;
      rv_r     <= 1'b0;
      br_r     <= 2'b00;
      rr_r     <= 2'b00;
      rd_r     <= 32'h0000_0000;
      run_r    <= `SCSC_CTRL_RST;
      isr_r    <= '0;
      imr_r    <= `SCSC_IMR_RST;
      irq_r    <= 1'b0;
    end else if (ce) begin
      aw_got_r <= aw_got_nxt;
      w_got_r  <= w_got_nxt;
      wa_r     <= wa_nxt;
      wd_r     <= wd_nxt;
      ws_r     <= ws_nxt;
      awr_r    <= awr_nxt;
      wr_r     <= wr_nxt;
      arr_r    <= arr_nxt;
      bv_r     <= bv_nxt;
      rv_r     <= rv_nxt;
      br_r     <= br_nxt;
      rr_r     <= rr_nxt;
      rd_r     <= rd_nxt;
      run_r    <= run_nxt;
      isr_r    <= isr_nxt;
      imr_r    <= imr_nxt;
      irq_r    <= irq_nxt;
    end
  end

  assign awready      = awr_r;
  assign wready       = wr_r;
  assign bvalid       = bv_r;
  assign bresp        = br_r;
  assign arready      = arr_r;
  assign rvalid       = rv_r;
  assign rresp        = rr_r;
  assign rdata        = rd_r;
  assign switch_drive = sw_r;
  assign irq          = irq_r;

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_uv_off;
    (ce && uv_lock) |=> !sw_r;
  endproperty
  a_uv_off: assert property (p_uv_off)
    else $error("switch on during under-voltage lockout");

  property p_uv_release;
    $rose(sw_r) |-> !$past(uv_lock) && $past(cyc_start);
  endproperty
  a_uv_release: assert property (p_uv_release)
    else $error("switch on before supply recovered");

  property p_ot_off;
    (ce && ot_lock) |=> !sw_r;
  endproperty
  a_ot_off: assert property (p_ot_off)
    else $error("switch on during thermal shutdown");

  property p_turn_on;
    (ce && st_r == SW_OFF && cyc_start && en_s && run_r
      && !uv_lock && !ot_lock) |=> sw_r && st_r == SW_BLANK;
  endproperty
  a_turn_on: assert property (p_turn_on)
    else $error("enabled cycle did not turn switch on");

  property p_no_mid_on;
    (ce && !cyc_start && !sw_r) |=> !sw_r;
  endproperty
  a_no_mid_on: assert property (p_no_mid_on)
    else $error("switch turned on away from cycle start");

  property p_ilim;
    (ce && st_r == SW_ON && ilim_s) |=> !sw_r ##0 isr_r[`SCSC_EV_LIM];
  endproperty
  a_ilim: assert property (p_ilim)
    else $error("current limit did not end the pulse");

  property p_blank;
    (ce && st_r == SW_BLANK && ilim_s && !uv_lock && !ot_lock
      && max_on_time_bound) |=> sw_r;
  endproperty
  a_blank: assert property (p_blank)
    else $error("current limit acted inside blanking");

  property p_duty;
    (ce && !max_on_time_bound) |=> !sw_r;
  endproperty
  a_duty: assert property (p_duty)
    else $error("on-time ran past the max window");

  property p_skip;
    (ce && cyc_start) |=> skip_r == !$past(en_s);
  endproperty
  a_skip: assert property (p_skip)
    else $error("skip flag does not follow the sample");

  property p_reset;
    $rose(aresetn) |-> !sw_r && uv_lock;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset did not leave the switch locked off");

  c_on:   cover property (ce && st_r == SW_BLANK ##1 st_r == SW_ON);
  c_skip: cover property (ce && cyc_start && !en_s);
  c_lim:  cover property (ce && ev_lim);
  c_duty: cover property (ce && ev_duty);
endmodule // scsc_top
